//--- move_ops_map.svh
// Opcode encodings, widths and timing counts for the data-move and
// interrupt-return execution unit. Assumes 14-bit program words.
`ifndef MOVE_OPS_MAP_SVH
`define MOVE_OPS_MAP_SVH

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define OPW_WIDTH          14
`define FADDR_WIDTH        7
`define DEST_BIT           7
`define LIT_WIDTH          8
`define PC_WIDTH           13

// ----------------------------------------------------------------
// Opcode patterns (mask then match; irq return is one exact word)
// ----------------------------------------------------------------
`define COPY_MASK          14'h3f00
`define COPY_MATCH         14'h0800
`define STORE_MASK         14'h3f80
`define STORE_MATCH        14'h0080
`define LIT_MASK           14'h3c00
`define LIT_MATCH          14'h3000
`define IDLE_MASK          14'h3f9f
`define IDLE_MATCH         14'h0000
`define IRQRET_WORD        14'h0009

// ----------------------------------------------------------------
// Control register field and cycle counts
// ----------------------------------------------------------------
`define IRQCTL_GLOBAL_EN_BIT 7
`define IRQCTL_RESET       8'h00
`define CYCLES_SINGLE      1
`define CYCLES_IRQRET      2

`endif

//--- move_ops_pkg.sv
// Types shared by the data-move and interrupt-return execution unit.
// Assumes nothing beyond the map header.
`default_nettype none

package move_ops_pkg;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_COPY,
      OP_STORE,
      OP_LIT,
      OP_IDLE,
      OP_IRQRET
   } op_kind_t;

   typedef enum logic [1:0] {
      ST_FETCH,
      ST_IRQRET2
   } exec_state_t;
endpackage

`default_nettype wire

//--- data_move_and_irq_return_ops.sv
// Execution unit for copy, store, load-literal, idle and interrupt return.
// Assumes the core presents one instruction word per instruction cycle on
// a one-cycle strobe, a register file with read data valid the same cycle,
// and a stack that gives its top combinationally and pops on a pulse.
`include "move_ops_map.svh"
`timescale 1ns/10ps
`default_nettype none

module data_move_and_irq_return_ops
   import move_ops_pkg::*;
#(
   parameter int OPW = `OPW_WIDTH,
   parameter int PCW = `PC_WIDTH
) (
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  wire logic                    instrValid,
   input  wire logic [OPW-1:0]          instrWord,
   input  wire logic [7:0]              fileRdData,
   input  wire logic [PCW-1:0]          stackTop,
   output logic [`FADDR_WIDTH-1:0]      fileAddr,
   output logic                         fileWrEn,
   output logic [7:0]                   fileWrData,
   output logic                         stackPop,
   output logic [7:0]                   acc,
   output logic                         zeroFlag,
   output logic [PCW-1:0]               pc,
   output logic [7:0]                   irqControlReg,
   output logic                         busy,
   output logic                         opDone,
   output logic                         badOp
);

   // Decode masks only serve the 14-bit word layout
   if (OPW != `OPW_WIDTH || PCW < 2) begin : g_width_check
      $error("Unsupported instruction or program counter width");
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   op_kind_t              kind;
   logic                  destSelf;
   logic [`FADDR_WIDTH-1:0] opAddr;

   always_comb begin
      destSelf = instrWord[`DEST_BIT];
      opAddr   = instrWord[`FADDR_WIDTH-1:0];
      if ((instrWord & `COPY_MASK) == `COPY_MATCH) begin
         kind = OP_COPY;
      end else if ((instrWord & `STORE_MASK) == `STORE_MATCH) begin
         kind = OP_STORE;
      // Don't-care bits ignored: any encoding in the group loads
      // tolerate zeroed bits
      end else if ((instrWord & `LIT_MASK) == `LIT_MATCH) begin
         kind = OP_LIT;
      end else if (instrWord == `IRQRET_WORD) begin
         kind = OP_IRQRET;
      end else if ((instrWord & `IDLE_MASK) == `IDLE_MATCH) begin
         kind = OP_IDLE;
      end else begin
         kind = OP_NONE;
      end
   end

   // ----------------------------------------------------------------
   // Execute state and architectural registers
   // ----------------------------------------------------------------
   exec_state_t     state;
   exec_state_t     next_state;
   logic [7:0]      next_acc;
   logic            next_zeroFlag;
   logic [PCW-1:0]  next_pc;
   logic [7:0]      next_irqControlReg;
   logic [`FADDR_WIDTH-1:0] next_fileAddr;
   logic            next_fileWrEn;
   logic [7:0]      next_fileWrData;
   logic            next_stackPop;
   logic            next_opDone;
   logic            next_badOp;

   always_comb begin
      next_state         = state;
      next_acc           = acc;
      next_zeroFlag      = zeroFlag;
      next_pc            = pc;
      next_irqControlReg = irqControlReg;
      next_fileAddr      = fileAddr;
      next_fileWrEn      = 1'b0;
      next_fileWrData    = fileWrData;
      next_stackPop      = 1'b0;
      next_opDone        = 1'b0;
      next_badOp         = 1'b0;
      unique case (state)
         ST_FETCH: begin
            if (instrValid) begin
               unique case (kind)
                  OP_COPY: begin
                     next_pc     = pc + PCW'(1);
                     next_opDone = 1'b1;
                     next_zeroFlag = (fileRdData == 8'h00);
                     if (destSelf) begin
                        next_fileAddr   = opAddr;
                        next_fileWrEn   = 1'b1;
                        next_fileWrData = fileRdData;
                     end else begin
                        next_acc = fileRdData;
                     end
                  end
                  OP_STORE: begin
                     next_fileAddr   = opAddr;
                     next_fileWrEn   = 1'b1;
                     next_fileWrData = acc;
                     next_pc         = pc + PCW'(1);
                     next_opDone     = 1'b1;
                  end
                  OP_LIT: begin
                     next_acc    = instrWord[`LIT_WIDTH-1:0];
                     next_pc     = pc + PCW'(1);
                     next_opDone = 1'b1;
                  end
                  OP_IDLE: begin
                     next_pc     = pc + PCW'(1);
                     next_opDone = 1'b1;
                  end
                  OP_IRQRET: begin
                     next_pc       = stackTop;
                     next_stackPop = 1'b1;
                     next_irqControlReg[`IRQCTL_GLOBAL_EN_BIT] = 1'b1;
                     next_state = ST_IRQRET2;
                  end
                  OP_NONE: begin
                     // Outside this unit's group; left to the core
                     next_badOp = 1'b1;
                  end
               endcase
            end
         end
         ST_IRQRET2: begin
            // Flushed fetch slot, no architectural change
            next_opDone = 1'b1;
            next_state  = ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state         <= ST_FETCH;
         acc           <= 8'h00;
         zeroFlag      <= 1'b0;
         pc            <= '0;
         irqControlReg <= `IRQCTL_RESET;
         fileAddr      <= '0;
         fileWrEn      <= 1'b0;
         fileWrData    <= 8'h00;
         stackPop      <= 1'b0;
         opDone        <= 1'b0;
         badOp         <= 1'b0;
      end else begin
         state         <= next_state;
         acc           <= next_acc;
         zeroFlag      <= next_zeroFlag;
         pc            <= next_pc;
         irqControlReg <= next_irqControlReg;
         fileAddr      <= next_fileAddr;
         fileWrEn      <= next_fileWrEn;
         fileWrData    <= next_fileWrData;
         stackPop      <= next_stackPop;
         opDone        <= next_opDone;
         badOp         <= next_badOp;
      end
   end

   // Requests during the second irq-return cycle are not taken
   assign busy = (state == ST_IRQRET2);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic fire;
   assign fire = instrValid && !busy;

   sequence s_irqret_issue;
      fire && kind == OP_IRQRET;
   endsequence

   sequence s_irqret_finish;
      stackPop && busy ##1 opDone && !busy;
   endsequence

   a_copy_to_acc: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_COPY && !destSelf |=> acc == $past(fileRdData) && !fileWrEn)
      else $error("copy to accumulator wrong");

   a_copy_writeback: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_COPY && destSelf
      |=> fileWrEn && fileAddr == $past(opAddr) && fileWrData == $past(fileRdData)
          && $stable(acc))
      else $error("copy write-back wrong");

   a_copy_zero: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_COPY |=> zeroFlag == ($past(fileRdData) == 8'h00))
      else $error("zero flag not from moved value");

   a_store_write: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_STORE
      |=> fileWrEn && fileWrData == $past(acc) && $stable(zeroFlag))
      else $error("store wrong or flag disturbed");

   a_literal_load: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_LIT
      |=> acc == $past(instrWord[7:0]) && $stable(zeroFlag) && !fileWrEn)
      else $error("literal load wrong");

   a_irqret_pop: assert property (@(posedge clk_sys) disable iff (reset)
      s_irqret_issue |=> stackPop && pc == $past(stackTop))
      else $error("irq return did not pop into pc");

   a_irqret_enable: assert property (@(posedge clk_sys) disable iff (reset)
      s_irqret_issue
      |=> irqControlReg[`IRQCTL_GLOBAL_EN_BIT] ##1 irqControlReg[`IRQCTL_GLOBAL_EN_BIT])
      else $error("global enable not set");

   a_irqret_two: assert property (@(posedge clk_sys) disable iff (reset)
      s_irqret_issue |=> s_irqret_finish ##0 $stable(zeroFlag))
      else $error("irq return not two cycles");

   a_single_cycle: assert property (@(posedge clk_sys) disable iff (reset)
      fire && (kind == OP_COPY || kind == OP_STORE || kind == OP_LIT)
      |=> opDone && !busy && pc == $past(pc) + PCW'(1))
      else $error("single-cycle op timing wrong");

   a_idle_quiet: assert property (@(posedge clk_sys) disable iff (reset)
      fire && kind == OP_IDLE
      |=> !fileWrEn && !stackPop && $stable(acc) && $stable(zeroFlag)
          && pc == $past(pc) + PCW'(1))
      else $error("idle changed state");

endmodule

`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the data-move and interrupt-return unit.
// Assumes the map header and package compile first; the bench acts as
// core, register file and stack, driving inputs on falling edges.
`timescale 1ns/10ps
`default_nettype none
`include "move_ops_map.svh"

module tb_top;
   import move_ops_pkg::*;

   logic                      clk_sys;
   logic                      reset;
   logic                      instrValid;
   logic [`OPW_WIDTH-1:0]     instrWord;
   logic [7:0]                fileRdData;
   logic [`PC_WIDTH-1:0]      stackTop;
   logic [`FADDR_WIDTH-1:0]   fileAddr;
   logic                      fileWrEn;
   logic [7:0]                fileWrData;
   logic                      stackPop;
   logic [7:0]                acc;
   logic                      zeroFlag;
   logic [`PC_WIDTH-1:0]      pc;
   logic [7:0]                irqControlReg;
   logic                      busy;
   logic                      opDone;
   logic                      badOp;
   logic [`PC_WIDTH-1:0]      expPc;
   int                        n_mismatch;
   int                        comparisons;

   data_move_and_irq_return_ops i_dut (
      .clk_sys(clk_sys), .reset(reset), .instrValid(instrValid),
      .instrWord(instrWord), .fileRdData(fileRdData), .stackTop(stackTop),
      .fileAddr(fileAddr), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
      .stackPop(stackPop), .acc(acc), .zeroFlag(zeroFlag), .pc(pc),
      .irqControlReg(irqControlReg), .busy(busy), .opDone(opDone),
      .badOp(badOp)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Holds the request one edge; caller decides whether to lower it
   task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic [12:0] top);
      instrValid = 1'b1;
      instrWord  = w;
      fileRdData = rd;
      stackTop   = top;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic done1;
      expPc = expPc + 13'h0001;
      chk("opDone", 16'h0001, {15'h0000, opDone});
      chk("pc", {3'h0, expPc}, {3'h0, pc});
      chk("badOp", 16'h0000, {15'h0000, badOp});
   endtask

   // Lowers the strobe for one edge so no signal is driven twice in one
   // time step; every one-cycle pulse must have dropped by then
   task automatic rest;
      instrValid = 1'b0;
      @(negedge clk_sys);
      chk("opDone", 16'h0000, {15'h0000, opDone});
      chk("fileWrEn", 16'h0000, {15'h0000, fileWrEn});
      chk("stackPop", 16'h0000, {15'h0000, stackPop});
      chk("badOp", 16'h0000, {15'h0000, badOp});
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_copy_acc;
      issue(`COPY_MATCH | 14'h007f, 8'h00, 13'h0000);
      done1();
      chk("acc", 16'h0000, {8'h00, acc});
      chk("zeroFlag", 16'h0001, {15'h0000, zeroFlag});
      chk("fileWrEn", 16'h0000, {15'h0000, fileWrEn});
      issue(`COPY_MATCH | 14'h0005, 8'ha5, 13'h0000);
      done1();
      chk("acc", 16'h00a5, {8'h00, acc});
      chk("zeroFlag", 16'h0000, {15'h0000, zeroFlag});
      rest();
      $display("test copy to accumulator done");
   endtask

   task automatic t_copy_back;
      issue(`COPY_MATCH | 14'h0080, 8'h3c, 13'h0000);
      done1();
      chk("fileWrEn", 16'h0001, {15'h0000, fileWrEn});
      chk("fileAddr", 16'h0000, {9'h000, fileAddr});
      chk("fileWrData", 16'h003c, {8'h00, fileWrData});
      chk("acc", 16'h00a5, {8'h00, acc});
      issue(`COPY_MATCH | 14'h00ff, 8'h00, 13'h0000);
      done1();
      chk("fileAddr", 16'h007f, {9'h000, fileAddr});
      chk("zeroFlag", 16'h0001, {15'h0000, zeroFlag});
      rest();
      $display("test copy back to file done");
   endtask

   task automatic t_store_lit;
      issue(`STORE_MATCH | 14'h007f, 8'h11, 13'h0000);
      done1();
      chk("fileWrEn", 16'h0001, {15'h0000, fileWrEn});
      chk("fileWrData", 16'h00a5, {8'h00, fileWrData});
      chk("fileAddr", 16'h007f, {9'h000, fileAddr});
      chk("zeroFlag", 16'h0001, {15'h0000, zeroFlag});
      // Don't-care bits left at zero
      issue(`LIT_MATCH | 14'h00ff, 8'h00, 13'h0000);
      done1();
      chk("acc", 16'h00ff, {8'h00, acc});
      chk("zeroFlag", 16'h0001, {15'h0000, zeroFlag});
      chk("fileWrEn", 16'h0000, {15'h0000, fileWrEn});
      issue(`LIT_MATCH | 14'h0000, 8'h00, 13'h0000);
      done1();
      chk("acc", 16'h0000, {8'h00, acc});
      rest();
      $display("test store and literal done");
   endtask

   task automatic t_idle;
      for (int i = 0; i < 4; i++) begin
         issue(`IDLE_MATCH | 14'(i * 32), 8'h5e, 13'h0000);
         done1();
         chk("acc", 16'h0000, {8'h00, acc});
         chk("fileWrEn", 16'h0000, {15'h0000, fileWrEn});
         chk("stackPop", 16'h0000, {15'h0000, stackPop});
      end
      rest();
      $display("test idle done");
   endtask

   task automatic t_irq_return;
      issue(`IRQRET_WORD, 8'h00, 13'h1abc);
      chk("pc", 16'h1abc, {3'h0, pc});
      chk("stackPop", 16'h0001, {15'h0000, stackPop});
      chk("globalIrqEnable", 16'h0080, {8'h00, irqControlReg});
      chk("busy", 16'h0001, {15'h0000, busy});
      chk("opDone", 16'h0000, {15'h0000, opDone});
      // Word offered while busy must be dropped
      instrWord = `LIT_MATCH | 14'h0077;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("opDone", 16'h0001, {15'h0000, opDone});
      chk("busy", 16'h0000, {15'h0000, busy});
      chk("acc", 16'h0000, {8'h00, acc});
      chk("zeroFlag", 16'h0001, {15'h0000, zeroFlag});
      chk("stackPop", 16'h0000, {15'h0000, stackPop});
      chk("globalIrqEnable", 16'h0080, {8'h00, irqControlReg});
      expPc = 13'h1abc;
      issue(`IDLE_MATCH, 8'h00, 13'h0000);
      done1();
      rest();
      $display("test interrupt return done");
   endtask

   // A word outside the group is flagged and leaves pc and stack alone
   task automatic t_bad_word;
      issue(14'h0100, 8'h00, 13'h1fff);
      chk("badOp", 16'h0001, {15'h0000, badOp});
      chk("opDone", 16'h0000, {15'h0000, opDone});
      chk("pc", {3'h0, expPc}, {3'h0, pc});
      chk("stackPop", 16'h0000, {15'h0000, stackPop});
      rest();
      $display("test unrecognised word done");
   endtask

   // Reset in mid-run must clear state that earlier scenarios set
   task automatic t_mid_reset;
      issue(`LIT_MATCH | 14'h005a, 8'h00, 13'h0000);
      done1();
      chk("acc", 16'h005a, {8'h00, acc});
      rest();
      reset = 1'b1;
      @(negedge clk_sys);
      reset = 1'b0;
      chk("pc", 16'h0000, {3'h0, pc});
      chk("acc", 16'h0000, {8'h00, acc});
      chk("zeroFlag", 16'h0000, {15'h0000, zeroFlag});
      chk("irqControlReg", 16'h0000, {8'h00, irqControlReg});
      chk("busy", 16'h0000, {15'h0000, busy});
      expPc = 13'h0000;
      issue(`IDLE_MATCH, 8'h00, 13'h0000);
      done1();
      rest();
      $display("test mid-run reset done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end

   initial begin
      n_mismatch  = 0;
      comparisons = 0;
      expPc       = 13'h0000;
      reset       = 1'b1;
      instrValid  = 1'b0;
      instrWord   = 14'h0000;
      fileRdData  = 8'h00;
      stackTop    = 13'h0000;
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      chk("pc", 16'h0000, {3'h0, pc});
      chk("irqControlReg", 16'h0000, {8'h00, irqControlReg});
      t_copy_acc();
      t_copy_back();
      t_store_lit();
      t_idle();
      t_irq_return();
      t_bad_word();
      t_mid_reset();
      summarize();
   end
endmodule

`default_nettype wire
